// file: hdl/tcu_pkg.sv
package tcu_pkg;

  // register addresses on the plain register port
  localparam logic [2:0] ADDR_CTRL    = 3'h0;
  localparam logic [2:0] ADDR_COUNT   = 3'h1;
  localparam logic [2:0] ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ADDR_FLAGS   = 3'h3;
  localparam logic [2:0] ADDR_MASK    = 3'h4;
  localparam logic [2:0] ADDR_ASYNC   = 3'h5;

  // bit positions in the flag, mask and async registers
  localparam int FLAG_OVF_BIT  = 0;
  localparam int FLAG_CMP_BIT  = 1;
  localparam int ASYNC_SEL_BIT = 0;

  // reset values
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;

  // extreme counter values
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hff;

  typedef enum logic [1:0] {
    WGM_NORMAL = 2'h0,
    WGM_PHASE  = 2'h1,
    WGM_CTC    = 2'h2,
    WGM_FAST   = 2'h3
  } tcu_wgm_e;

  typedef enum logic [1:0] {
    COM_OFF    = 2'h0,
    COM_TOGGLE = 2'h1,
    COM_CLEAR  = 2'h2,
    COM_SET    = 2'h3
  } tcu_com_e;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       force_cmp;
    tcu_com_e   com;
    tcu_wgm_e   wgm;
    logic [2:0] cs;
  } tcu_ctrl_s;

  // prescaler tap masks: divide by 1, 8, 32, 64, 128, 256, 1024
  function automatic logic [9:0] tcu_pre_mask(input logic [2:0] cs);
    case (cs)
      3'h2:    return 10'h007;
      3'h3:    return 10'h01f;
      3'h4:    return 10'h03f;
      3'h5:    return 10'h07f;
      3'h6:    return 10'h0ff;
      3'h7:    return 10'h3ff;
      default: return 10'h000;
    endcase
  endfunction

endpackage

// file: hdl/tcu_timer8.sv
// Behaviour
// - 8-bit counter and compare, always compared
// - clock select zero stops the counter
// - tick from core clock or crystal
// - each tick clears, increments or decrements
// - CPU counter write beats count or clear
// - overflow flag set per mode, interrupts
// - match sets compare flag next tick
// - enabled compare flag raises interrupt request
// - compare flag cleared by ack or one
// - output from match, mode and extremes
// - compare buffered only in PWM modes
// - buffer copied to active at top
// - CPU reaches buffer or active register
// - force strobe acts like match in non-PWM modes only, no flag
// - counter write blocks next tick's match
// - output register kept across mode change
// - output mode change acts immediately
// - output mode sets action and pin source
// - bottom at 0x00, max at 0xff
// - top is 0xff or compare value
// - normal mode wraps, overflow at zero
// - mode 2 clears counter on match
// - mode 3 fast single-slope PWM
// - output mode zero does nothing
`timescale 1ns/10ps
`default_nettype none

module tcu_timer8 (
  input  wire logic       CORE_CLK,
  input  wire logic       ARST_N,
  input  wire logic [2:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       CRYSTAL_PIN_IN,
  output logic            CRYSTAL_PIN_OUT,
  input  wire logic       IRQ_OVF_ACK,
  input  wire logic       IRQ_CMP_ACK,
  output logic            IRQ_OVF,
  output logic            IRQ_CMP,
  output logic            COMPARE_OUTPUT,
  output logic            COMPARE_PIN_SEL
);

  tcu_pkg::tcu_ctrl_s ctrl_q;
  logic [7:0]         cnt_q, cnt_d;
  logic [7:0]         act_q, buf_q;
  logic [9:0]         pre_q;
  logic [1:0]         mask_q;
  logic               async_q;
  logic               xtal_q;
  logic               dir_up_q, dir_up_d;
  logic               blk_q;
  logic               ovf_q, cmp_q;
  logic               oc_q, oc_d;

  // register port decode
  wire tcu_pkg::tcu_ctrl_s wr_ctrl_val = tcu_pkg::tcu_ctrl_s'(REG_WDATA);
  wire wr_ctrl    = REG_WR && (REG_ADDR == tcu_pkg::ADDR_CTRL);
  wire wr_count   = REG_WR && (REG_ADDR == tcu_pkg::ADDR_COUNT);
  wire wr_cmp     = REG_WR && (REG_ADDR == tcu_pkg::ADDR_COMPARE);
  wire wr_flags   = REG_WR && (REG_ADDR == tcu_pkg::ADDR_FLAGS);
  wire wr_mask    = REG_WR && (REG_ADDR == tcu_pkg::ADDR_MASK);
  wire wr_async   = REG_WR && (REG_ADDR == tcu_pkg::ADDR_ASYNC);

  // mode decode; PWM modes have the low mode bit set
  wire is_pwm     = ctrl_q.wgm[0];
  wire is_phase   = (ctrl_q.wgm == tcu_pkg::WGM_PHASE);
  wire is_ctc     = (ctrl_q.wgm == tcu_pkg::WGM_CTC);

  // extreme values and comparator
  wire at_bottom  = (cnt_q == tcu_pkg::COUNT_BOTTOM);
  wire at_max     = (cnt_q == tcu_pkg::COUNT_MAX);
  wire match      = (cnt_q == act_q);
  wire at_top     = is_ctc ? match : at_max;

  // tick source: crystal edge when async selected, else every core cycle
  wire xtal_rise  = CRYSTAL_PIN_IN && !xtal_q;
  wire src_en     = async_q ? xtal_rise : 1'b1;
  wire [9:0] tap  = tcu_pkg::tcu_pre_mask(ctrl_q.cs);
  wire run        = (ctrl_q.cs != 3'h0);
  wire tick       = run && src_en && ((pre_q & tap) == tap);
  wire tick_run   = tick && !wr_count;

  // a counter write suppresses the match seen on the next tick
  wire cmp_hit    = match && !blk_q;
  wire cmp_ev     = tick && cmp_hit;
  wire force_ev   = wr_ctrl && wr_ctrl_val.force_cmp && !wr_ctrl_val.wgm[0];

  // flag set and clear terms; a set in the same cycle wins
  wire ovf_set    = tick_run && (is_phase ? at_bottom : at_max);
  wire ovf_clr    = (wr_flags && REG_WDATA[tcu_pkg::FLAG_OVF_BIT]) || IRQ_OVF_ACK;
  wire cmp_clr    = (wr_flags && REG_WDATA[tcu_pkg::FLAG_CMP_BIT]) || IRQ_CMP_ACK;
  wire buf_load   = is_pwm && tick_run && at_max;

  // output mode in force, taken from the write itself on a strobe
  wire tcu_pkg::tcu_com_e com_eff = force_ev ? wr_ctrl_val.com : ctrl_q.com;

  // counter next value per mode
  always_comb begin
    cnt_d = cnt_q;
    if (wr_count) begin
      cnt_d = REG_WDATA;
    end else if (tick) begin
      unique case (ctrl_q.wgm)
        tcu_pkg::WGM_NORMAL: cnt_d = cnt_q + 8'h01;
        tcu_pkg::WGM_FAST:   cnt_d = cnt_q + 8'h01;
        tcu_pkg::WGM_CTC:    cnt_d = cmp_hit ? 8'h00 : cnt_q + 8'h01;
        tcu_pkg::WGM_PHASE: begin
          if (dir_up_q) begin
            cnt_d = at_max ? cnt_q - 8'h01 : cnt_q + 8'h01;
          end else begin
            cnt_d = at_bottom ? cnt_q + 8'h01 : cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  // count direction, only meaningful in dual-slope mode
  always_comb begin
    dir_up_d = dir_up_q;
    if (!is_phase) begin
      dir_up_d = 1'b1;
    end else if (tick_run && dir_up_q && at_max) begin
      dir_up_d = 1'b0;
    end else if (tick_run && !dir_up_q && at_bottom) begin
      dir_up_d = 1'b1;
    end
  end

  // waveform generator; a mode change alone never touches oc_q
  always_comb begin
    oc_d = oc_q;
    unique case (ctrl_q.wgm)
      tcu_pkg::WGM_NORMAL, tcu_pkg::WGM_CTC: begin
        if (cmp_ev || force_ev) begin
          unique case (com_eff)
            tcu_pkg::COM_OFF:    oc_d = oc_q;
            tcu_pkg::COM_TOGGLE: oc_d = !oc_q;
            tcu_pkg::COM_CLEAR:  oc_d = 1'b0;
            tcu_pkg::COM_SET:    oc_d = 1'b1;
          endcase
        end
      end
      tcu_pkg::WGM_FAST: begin
        // wrap to bottom wins so a compare at max gives a steady level
        if (ctrl_q.com[1] && tick_run && at_max) begin
          oc_d = (ctrl_q.com == tcu_pkg::COM_CLEAR);
        end else if (ctrl_q.com[1] && cmp_ev) begin
          oc_d = (ctrl_q.com == tcu_pkg::COM_SET);
        end
      end
      tcu_pkg::WGM_PHASE: begin
        if (ctrl_q.com[1] && cmp_ev) begin
          oc_d = dir_up_q ? (ctrl_q.com == tcu_pkg::COM_SET)
                          : (ctrl_q.com == tcu_pkg::COM_CLEAR);
        end
      end
    endcase
  end

  // control, mask and async select; output mode takes hold at once
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q  <= tcu_pkg::tcu_ctrl_s'(tcu_pkg::CTRL_RST);
      mask_q  <= 2'h0;
      async_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q           <= wr_ctrl_val;
        ctrl_q.force_cmp <= 1'b0;                                    // strobe only
      end
      if (wr_mask) begin
        mask_q <= REG_WDATA[1:0];
      end
      if (wr_async) begin
        async_q <= REG_WDATA[tcu_pkg::ASYNC_SEL_BIT];
      end
    end
  end

  // crystal edge detect and amplifier feedback; pin is core-synchronous
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      xtal_q          <= 1'b0;
      CRYSTAL_PIN_OUT <= 1'b0;
    end else begin
      xtal_q          <= CRYSTAL_PIN_IN;
      CRYSTAL_PIN_OUT <= !CRYSTAL_PIN_IN;
    end
  end

  // prescaler free-runs on the source while a clock is selected
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_q <= 10'h000;
    end else if (!run) begin
      pre_q <= 10'h000;
    end else if (src_en) begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // counter, direction, match blocking and output register
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_q    <= tcu_pkg::COUNT_RST;
      dir_up_q <= 1'b1;
      blk_q    <= 1'b0;
      oc_q     <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      dir_up_q <= dir_up_d;
      blk_q    <= wr_count || (blk_q && !tick);
      oc_q     <= oc_d;
    end
  end

  // compare value: direct in non-PWM, buffered in PWM
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      act_q <= tcu_pkg::COMPARE_RST;
      buf_q <= tcu_pkg::COMPARE_RST;
    end else begin
      if (wr_cmp) begin
        buf_q <= REG_WDATA;
      end
      if (wr_cmp && !is_pwm) begin
        act_q <= REG_WDATA;
      end else if (buf_load) begin
        act_q <= buf_q;
      end
    end
  end

  // sticky flags, hardware set beats any clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ovf_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      ovf_q <= ovf_set || (ovf_q && !ovf_clr);
      cmp_q <= cmp_ev || (cmp_q && !cmp_clr);
    end
  end

  // read mux; force strobe and unmapped addresses read as zero
  wire [7:0] rd_ctrl  = {1'b0, ctrl_q.com, ctrl_q.wgm, ctrl_q.cs};
  wire [7:0] rd_cmp   = is_pwm ? buf_q : act_q;
  wire [7:0] rd_flags = {6'h00, cmp_q, ovf_q};
  wire [7:0] rd_mux   =
    (REG_ADDR == tcu_pkg::ADDR_CTRL)    ? rd_ctrl :
    (REG_ADDR == tcu_pkg::ADDR_COUNT)   ? cnt_q :
    (REG_ADDR == tcu_pkg::ADDR_COMPARE) ? rd_cmp :
    (REG_ADDR == tcu_pkg::ADDR_FLAGS)   ? rd_flags :
    (REG_ADDR == tcu_pkg::ADDR_MASK)    ? {6'h00, mask_q} :
    (REG_ADDR == tcu_pkg::ADDR_ASYNC)   ? {7'h00, async_q} : 8'h00;

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 8'h00;
    end
  end

  // interrupt requests and pin source select
  assign IRQ_OVF         = ovf_q && mask_q[tcu_pkg::FLAG_OVF_BIT];
  assign IRQ_CMP         = cmp_q && mask_q[tcu_pkg::FLAG_CMP_BIT];
  assign COMPARE_OUTPUT  = oc_q;
  assign COMPARE_PIN_SEL = (ctrl_q.com != tcu_pkg::COM_OFF);

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_arm;
    wr_count && !cmp_q && !tick;
  endsequence
  sequence s_next_tick;
    tick && !wr_count;
  endsequence

  AST_STOPPED_HOLDS: assert property (
    (ctrl_q.cs == 3'h0 && !wr_count) |=> $stable(cnt_q)
  ) else $error("counter moved with no clock selected");

  AST_WRITE_WINS: assert property (
    (wr_count && tick) |=> (cnt_q == $past(REG_WDATA))
  ) else $error("counter write lost against a tick");

  AST_CMP_FLAG: assert property (
    (tick && match && !blk_q) |=> cmp_q
  ) else $error("match did not set compare flag");

  AST_BLOCKED: assert property (
    s_arm ##1 s_next_tick |=> !cmp_q
  ) else $error("match after counter write not blocked");

  AST_FORCE_NO_FLAG: assert property (
    (force_ev && !tick && !cmp_q) |=> (!cmp_q && $stable(cnt_q))
  ) else $error("force strobe touched flag or counter");

  AST_CTC_CLEAR: assert property (
    (is_ctc && tick && cmp_hit && !wr_count) |=> (cnt_q == 8'h00)
  ) else $error("ctc did not clear on match");

  AST_NORMAL_WRAP: assert property (
    (ctrl_q.wgm == tcu_pkg::WGM_NORMAL && tick_run && at_max)
      |=> (ovf_q && cnt_q == 8'h00)
  ) else $error("normal wrap without overflow");

  AST_PHASE_TURN: assert property (
    (is_phase && tick_run && dir_up_q && at_max) |=> (!dir_up_q && cnt_q == 8'hfe)
  ) else $error("phase mode did not turn at max");

  AST_BUF_HOLD: assert property (
    (is_pwm && !buf_load) |=> $stable(act_q)
  ) else $error("active compare changed away from top");

  AST_COM_OFF: assert property (
    (ctrl_q.com == tcu_pkg::COM_OFF && !force_ev) |=> $stable(oc_q)
  ) else $error("output moved with output mode zero");

  AST_CMP_IRQ: assert property (
    (cmp_q && mask_q[1]) |-> IRQ_CMP
  ) else $error("enabled compare flag gave no request");

endmodule

`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } tcu_row_s;

  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       xtal = 1'b0;
  logic       xtal_out;
  logic       ack_ovf;
  logic       ack_cmp;
  logic       irq_ovf;
  logic       irq_cmp;
  logic       cmp_out;
  logic       pin_sel;
  logic       en_ovf = 1'b0;
  logic       en_cmp = 1'b0;
  logic [7:0] rv;
  int         n_errors = 0;
  int         cmp_count = 0;
  // write-then-read rows: address, write data, expected read
  tcu_row_s   rows [10] = '{'{3'h4, 8'h03, 8'h03}, '{3'h4, 8'h00, 8'h00},
    '{3'h5, 8'h01, 8'h01}, '{3'h5, 8'h00, 8'h00}, '{3'h2, 8'h5a, 8'h5a},
    '{3'h1, 8'h33, 8'h33}, '{3'h0, 8'hfa, 8'h7a}, '{3'h0, 8'h00, 8'h00},
    '{3'h6, 8'hff, 8'h00}, '{3'h3, 8'h00, 8'h00}};

  tcu_timer8 DUT (
    .CORE_CLK       (clk),
    .ARST_N         (arst_n),
    .REG_ADDR       (reg_addr),
    .REG_WDATA      (reg_wdata),
    .REG_WR         (reg_wr),
    .REG_RD         (reg_rd),
    .REG_RDATA      (reg_rdata),
    .CRYSTAL_PIN_IN (xtal),
    .CRYSTAL_PIN_OUT(xtal_out),
    .IRQ_OVF_ACK    (ack_ovf),
    .IRQ_CMP_ACK    (ack_cmp),
    .IRQ_OVF        (irq_ovf),
    .IRQ_CMP        (irq_cmp),
    .COMPARE_OUTPUT (cmp_out),
    .COMPARE_PIN_SEL(pin_sel)
  );

  tcu_cpu_model cpu_ovf (.clk(clk), .rst_n(arst_n), .irq(irq_ovf), .en(en_ovf), .ack(ack_ovf));
  tcu_cpu_model cpu_cmp (.clk(clk), .rst_n(arst_n), .irq(irq_cmp), .en(en_cmp), .ack(ack_cmp));

  // 250 MHz core clock
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_rng(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
    cmp_count++;
    if (!(g >= lo && g <= hi) || $isunknown(g)) begin
      n_errors++;
      $display("BAD %0t got %h outside %h..%h", $time, g, lo, hi);
    end
  endtask

  // run the counter with control value ctrl for n cycles, then stop it
  task automatic run(input logic [7:0] ctrl, input int n);
    wr(3'h0, ctrl);
    repeat (n) @(posedge clk);
    wr(3'h0, 8'h00);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the roughly one thousand cycles of the tests
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(i[2:0], rv);
      chk8(rv, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      chk8(rv, rows[i].e);
    end
    // stopped counter holds a written value
    wr(3'h1, 8'h55);
    repeat (10) @(posedge clk);
    rd(3'h1, rv);
    chk8(rv, 8'h55);
    // match sets flag, write one clears it
    wr(3'h1, 8'h3e);
    wr(3'h2, 8'h40);
    run(8'h01, 8);
    rd(3'h3, rv);
    chk8(rv, 8'h02);
    wr(3'h3, 8'h02);
    rd(3'h3, rv);
    chk8(rv, 8'h00);
    // count written equal to compare while stopped: first match lost
    wr(3'h1, 8'h40);
    run(8'h01, 8);
    rd(3'h3, rv);
    chk8(rv, 8'h00);
    // normal mode wrap sets overflow only
    wr(3'h1, 8'hfa);
    run(8'h01, 12);
    rd(3'h3, rv);
    chk8(rv, 8'h01);
    wr(3'h4, 8'h01);
    @(negedge clk);
    chk8({7'h0, irq_ovf}, 8'h01);
    chk8({7'h0, irq_cmp}, 8'h00);
    @(posedge clk);
    en_ovf <= 1'b1;
    repeat (10) @(posedge clk);
    chk8({7'h0, irq_ovf}, 8'h00);
    // clear on match keeps counter at or below compare
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h10);
    run(8'h11, 40);
    rd(3'h1, rv);
    chk_rng(rv, 8'h00, 8'h10);
    rd(3'h3, rv);
    chk8(rv, 8'h02);
    wr(3'h4, 8'h02);
    @(negedge clk);
    chk8({7'h0, irq_cmp}, 8'h01);
    @(posedge clk);
    en_cmp <= 1'b1;
    repeat (10) @(posedge clk);
    rd(3'h3, rv);
    chk8(rv, 8'h00);
    // prescaler divide by 8
    wr(3'h1, 8'h00);
    run(8'h02, 80);
    rd(3'h1, rv);
    chk_rng(rv, 8'h09, 8'h0b);
    // force strobe sets, clears, toggles or keeps the output per output mode
    wr(3'h1, 8'h23);
    wr(3'h0, 8'he0);
    @(negedge clk);
    chk8({6'h0, pin_sel, cmp_out}, 8'h03);
    wr(3'h0, 8'hc0);
    @(negedge clk);
    chk8({7'h0, cmp_out}, 8'h00);
    wr(3'h0, 8'ha0);
    @(negedge clk);
    chk8({7'h0, cmp_out}, 8'h01);
    wr(3'h0, 8'h80);
    @(negedge clk);
    chk8({6'h0, pin_sel, cmp_out}, 8'h01);
    rd(3'h1, rv);
    chk8(rv, 8'h23);
    rd(3'h3, rv);
    chk8(rv, 8'h00);
    wr(3'h0, 8'h18);
    @(negedge clk);
    chk8({7'h0, cmp_out}, 8'h01);
    // fast pwm: writes land in the buffer, copied at max
    wr(3'h2, 8'h77);
    rd(3'h2, rv);
    chk8(rv, 8'h77);
    wr(3'h0, 8'h00);
    rd(3'h2, rv);
    chk8(rv, 8'h10);
    wr(3'h0, 8'h18);
    run(8'h19, 300);
    rd(3'h2, rv);
    chk8(rv, 8'h77);
    // phase correct: 255 ticks up to max, then down for the rest
    wr(3'h1, 8'h00);
    run(8'h09, 300);
    rd(3'h1, rv);
    chk_rng(rv, 8'hce, 8'hd2);
    // crystal source: one tick per rising edge
    wr(3'h1, 8'h00);
    wr(3'h5, 8'h01);
    wr(3'h0, 8'h01);
    repeat (5) begin
      repeat (4) @(posedge clk);
      xtal <= 1'b1;
      repeat (4) @(posedge clk);
      xtal <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chk8({7'h0, xtal_out}, 8'h01);
    wr(3'h0, 8'h00);
    rd(3'h1, rv);
    chk8(rv, 8'h05);
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: verification/tcu_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

// cpu side: services a pending interrupt a few cycles after it shows
module tcu_cpu_model #(
  parameter int LAT = 3
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic irq,
  input  wire logic en,
  output logic      ack
);
  int wait_q;

  // one-cycle ack pulse; the gap lets the flag drop before a second one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 0;
      ack    <= 1'b0;
    end else begin
      ack <= 1'b0;
      if (irq && en && !ack) begin
        wait_q <= wait_q + 1;
        if (wait_q == LAT) begin
          ack    <= 1'b1;
          wait_q <= 0;
        end
      end
    end
  end
endmodule
`default_nettype wire
